//--- pkg/cabu_defines.svh
`ifndef CABU_DEFINES_SVH
`define CABU_DEFINES_SVH

// i/o space offsets of the two registers this block owns
`define CABU_ADDR_STACK_POINTER 6'h3D
`define CABU_ADDR_STATUS_FLAGS 6'h3F

// status_flags bit positions
`define CABU_FLAG_C 0
`define CABU_FLAG_Z 1
`define CABU_FLAG_N 2
`define CABU_FLAG_V 3
`define CABU_FLAG_S 4
`define CABU_FLAG_H 5

// flag update masks per instruction class
`define CABU_MASK_ARITH 8'h2F
`define CABU_MASK_WORD 8'h1F
`define CABU_MASK_LOGIC 8'h0E
`define CABU_MASK_NONE 8'h00

// reset values
`define CABU_RST_STATUS_FLAGS 8'h00
`define CABU_RST_STACK_POINTER 8'h00

// execution times in clock cycles
`define CABU_CYC_SINGLE 2'h1
`define CABU_CYC_WORD 2'h2
`define CABU_CYC_JUMP 2'h2
`define CABU_CYC_CALL 2'h3
`define CABU_CYC_SKIP 2'h2

// constants used by the datapath
`define CABU_ALL_ONES 8'hFF
`define CABU_Z_LOW_REG 5'h1E
`define CABU_Z_HIGH_REG 5'h1F
`define CABU_CALL_SP_STEP 8'h02

`endif

//--- pkg/cabu_pkg.sv
package cabu_pkg;

    // instructions accepted on the issue port
    typedef enum logic [4:0] {
        op_nop, op_add, op_add_carry, op_sub, op_subtract_constant, op_subtract_borrow,
        op_subtract_borrow_constant, op_and, op_and_constant, op_or, op_or_constant,
        op_exclusive_or_regs, op_set_bits_masked, op_clear_bits_masked, op_load_all_ones,
        op_inc, op_dec, op_test_register, op_clear_register, op_word_add_immediate,
        op_word_subtract_immediate, op_relative_jump, op_indirect_jump_z, op_relative_call,
        op_indirect_call_z, op_compare_skip_equal, op_compare, op_compare_with_carry,
        op_compare_immediate, op_skip_bit_clear, op_skip_bit_set
    } cabu_op_type;

    // byte alu functions
    typedef enum logic [2:0] {
        func_add, func_sub, func_and, func_or, func_xor, func_pass
    } cabu_func_type;

    typedef enum logic {
        st_idle, st_busy
    } cabu_state_type;

endpackage : cabu_pkg

//--- hw/cabu_alu.sv
module cabu_alu (
    input wire logic [7:0] a_in,
    input wire logic [7:0] b_in,
    input wire logic carry_in,
    input wire cabu_pkg::cabu_func_type func_in,
    output logic [7:0] res_out,
    output logic c_out,
    output logic h_out,
    output logic v_out,
    output logic n_out,
    output logic z_out
);

    logic [8:0] sum9;
    logic [8:0] dif9;

    // nine-bit sums so carry and borrow fall out of the top bit
    assign sum9 = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in};
    assign dif9 = {1'b0, a_in} - {1'b0, b_in} - {8'h00, carry_in};

    // result select
    always_comb begin
        case (func_in)
            cabu_pkg::func_add: res_out = sum9[7:0];
            cabu_pkg::func_sub: res_out = dif9[7:0];
            cabu_pkg::func_and: res_out = a_in & b_in;
            cabu_pkg::func_or: res_out = a_in | b_in;
            cabu_pkg::func_xor: res_out = a_in ^ b_in;
            default: res_out = a_in;
        endcase
    end

    // flags; logic functions report no overflow, carry and half carry are masked off by the caller
    always_comb begin
        c_out = 1'b0;
        h_out = 1'b0;
        v_out = 1'b0;
        if (func_in == cabu_pkg::func_add) begin
            c_out = sum9[8];
            h_out = (a_in[3] & b_in[3]) | (b_in[3] & ~res_out[3]) | (~res_out[3] & a_in[3]);
            v_out = (a_in[7] & b_in[7] & ~res_out[7]) | (~a_in[7] & ~b_in[7] & res_out[7]);
        end else if (func_in == cabu_pkg::func_sub) begin
            c_out = (~a_in[7] & b_in[7]) | (b_in[7] & res_out[7]) | (res_out[7] & ~a_in[7]);
            h_out = (~a_in[3] & b_in[3]) | (b_in[3] & res_out[3]) | (res_out[3] & ~a_in[3]);
            v_out = (a_in[7] & ~b_in[7] & ~res_out[7]) | (~a_in[7] & b_in[7] & res_out[7]);
        end
    end

    assign n_out = res_out[7];
    assign z_out = (res_out == 8'h00);

endmodule : cabu_alu

//--- hw/cabu_core.sv
// Our own choice: the plain strobed port.
`include "cabu_defines.svh"


module cabu_core #(
    parameter int PC_W = 11
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic start_in,
    input wire cabu_pkg::cabu_op_type op_in,
    input wire logic [4:0] rd_sel_in,
    input wire logic [4:0] rr_sel_in,
    input wire logic [7:0] imm_in,
    input wire logic [2:0] bit_sel_in,
    input wire logic [11:0] offset_in,
    input wire logic next_two_words_in,
    output logic ready_out,
    output logic done_out,
    output logic [PC_W-1:0] pc_out,
    output logic call_out,
    output logic [PC_W-1:0] return_addr_out,
    input wire logic rf_wr_in,
    input wire logic [4:0] rf_addr_in,
    input wire logic [7:0] rf_wdata_in,
    output logic [7:0] rf_rdata_out,
    input wire logic [5:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out
);

    logic [7:0] rf [32];
    logic [7:0] status_flags_reg;
    logic [7:0] sp_reg;
    logic [PC_W-1:0] pc_reg;
    cabu_pkg::cabu_state_type state_reg;
    logic [1:0] cnt_reg;
    logic done_reg;
    logic call_reg;
    logic [PC_W-1:0] ret_reg;
    logic [7:0] rd_data_reg;
    logic [7:0] rf_rd_reg;
    // pending results of a multi-cycle instruction
    logic pend_wr_reg;
    logic pend_wr_hi_reg;
    logic [4:0] pend_addr_reg;
    logic [7:0] pend_lo_reg;
    logic [7:0] pend_hi_reg;
    logic [7:0] pend_flags_reg;
    logic [7:0] pend_mask_reg;
    logic [PC_W-1:0] pend_pc_reg;
    logic pend_call_reg;

    // decode outputs
    cabu_pkg::cabu_func_type dec_func;
    logic [7:0] dec_b;
    logic dec_use_carry;
    logic [7:0] dec_mask;
    logic [1:0] dec_cycles;
    logic dec_wr;
    logic dec_word;
    logic dec_call;
    logic [PC_W-1:0] dec_pc;
    logic dec_skip;

    ////////////////////////////////////////////////////////////////////////////
    // operand fetch and byte alu

    wire [7:0] a_opnd = rf[rd_sel_in];
    wire [7:0] r_opnd = rf[rr_sel_in];
    wire [7:0] word_lo = rf[rd_sel_in];
    wire [7:0] word_hi = rf[rd_sel_in + 5'h01];
    wire [15:0] word_val = {word_hi, word_lo};
    wire [15:0] word_k = {10'h000, imm_in[5:0]};
    wire [15:0] z_ptr = {rf[`CABU_Z_HIGH_REG], rf[`CABU_Z_LOW_REG]};
    wire [PC_W-1:0] pc_inc = pc_reg + PC_W'(1);
    wire [PC_W-1:0] pc_rel = pc_inc + PC_W'(offset_in);
    wire [PC_W-1:0] pc_skip = pc_inc + (next_two_words_in ? PC_W'(2) : PC_W'(1));
    wire start_acc = start_in && ready_out;
    wire carry_now = status_flags_reg[`CABU_FLAG_C];

    logic [7:0] alu_res;
    logic alu_c;
    logic alu_h;
    logic alu_v;
    logic alu_n;
    logic alu_z;

    cabu_alu u_alu (
        .a_in(a_opnd),
        .b_in(dec_b),
        .carry_in(dec_use_carry & carry_now),
        .func_in(dec_func),
        .res_out(alu_res),
        .c_out(alu_c),
        .h_out(alu_h),
        .v_out(alu_v),
        .n_out(alu_n),
        .z_out(alu_z)
    );

    // word arithmetic on the register pair; the immediate is six bits wide
    wire word_sub = (op_in == cabu_pkg::op_word_subtract_immediate);
    wire [15:0] word_res = word_sub ? word_val - word_k : word_val + word_k;
    wire word_v = word_sub ? (word_hi[7] & ~word_res[15]) : (~word_hi[7] & word_res[15]);
    wire word_c = word_sub ? (word_res[15] & ~word_hi[7]) : (~word_res[15] & word_hi[7]);
    wire word_z = (word_res == 16'h0000);
    wire [7:0] word_flags = {3'b000, word_res[15] ^ word_v, word_v, word_res[15], word_z, word_c};
    wire [7:0] byte_flags = {2'b00, alu_h, alu_n ^ alu_v, alu_v, alu_n, alu_z, alu_c};
    wire [7:0] new_flags = dec_word ? word_flags : byte_flags;
    wire [7:0] new_lo = dec_word ? word_res[7:0] : alu_res;

    ////////////////////////////////////////////////////////////////////////////
    // instruction decode

    always_comb begin
        dec_func = cabu_pkg::func_pass;
        dec_b = r_opnd;
        dec_use_carry = 1'b0;
        dec_mask = `CABU_MASK_NONE;
        dec_cycles = `CABU_CYC_SINGLE;
        dec_wr = 1'b0;
        dec_word = 1'b0;
        dec_call = 1'b0;
        dec_pc = pc_inc;
        dec_skip = 1'b0;
        case (op_in)
            cabu_pkg::op_add, cabu_pkg::op_add_carry: begin
                dec_func = cabu_pkg::func_add;
                dec_use_carry = (op_in == cabu_pkg::op_add_carry);
                dec_mask = `CABU_MASK_ARITH;
                dec_wr = 1'b1;
            end
            cabu_pkg::op_sub, cabu_pkg::op_subtract_borrow: begin
                dec_func = cabu_pkg::func_sub;
                dec_use_carry = (op_in == cabu_pkg::op_subtract_borrow);
                dec_mask = `CABU_MASK_ARITH;
                dec_wr = 1'b1;
            end
            cabu_pkg::op_subtract_constant, cabu_pkg::op_subtract_borrow_constant: begin
                dec_func = cabu_pkg::func_sub;
                dec_b = imm_in;
                dec_use_carry = (op_in == cabu_pkg::op_subtract_borrow_constant);
                dec_mask = `CABU_MASK_ARITH;
                dec_wr = 1'b1;
            end
            cabu_pkg::op_and, cabu_pkg::op_and_constant, cabu_pkg::op_clear_bits_masked: begin
                dec_func = cabu_pkg::func_and;
                if (op_in == cabu_pkg::op_and_constant) begin
                    dec_b = imm_in;
                end else if (op_in == cabu_pkg::op_clear_bits_masked) begin
                    dec_b = `CABU_ALL_ONES - imm_in;
                end
                dec_mask = `CABU_MASK_LOGIC;
                dec_wr = 1'b1;
            end
            cabu_pkg::op_or, cabu_pkg::op_or_constant, cabu_pkg::op_set_bits_masked: begin
                dec_func = cabu_pkg::func_or;
                dec_b = (op_in == cabu_pkg::op_or) ? r_opnd : imm_in;
                dec_mask = `CABU_MASK_LOGIC;
                dec_wr = 1'b1;
            end
            cabu_pkg::op_exclusive_or_regs: begin
                dec_func = cabu_pkg::func_xor;
                dec_mask = `CABU_MASK_LOGIC;
                dec_wr = 1'b1;
            end
            cabu_pkg::op_load_all_ones: begin
                dec_func = cabu_pkg::func_or;
                dec_b = `CABU_ALL_ONES;
                dec_wr = 1'b1;
            end
            cabu_pkg::op_inc, cabu_pkg::op_dec: begin
                // overflow of the add or subtract of one is exactly the 7F/80 crossing
                dec_func = (op_in == cabu_pkg::op_inc) ? cabu_pkg::func_add : cabu_pkg::func_sub;
                dec_b = 8'h01;
                dec_mask = `CABU_MASK_LOGIC;
                dec_wr = 1'b1;
            end
            cabu_pkg::op_test_register: begin
                dec_func = cabu_pkg::func_and;
                dec_b = a_opnd;
                dec_mask = `CABU_MASK_LOGIC;
                dec_wr = 1'b1;
            end
            cabu_pkg::op_clear_register: begin
                dec_func = cabu_pkg::func_xor;
                dec_b = a_opnd;
                dec_mask = `CABU_MASK_LOGIC;
                dec_wr = 1'b1;
            end
            cabu_pkg::op_word_add_immediate, cabu_pkg::op_word_subtract_immediate: begin
                dec_word = 1'b1;
                dec_mask = `CABU_MASK_WORD;
                dec_cycles = `CABU_CYC_WORD;
                dec_wr = 1'b1;
            end
            cabu_pkg::op_relative_jump, cabu_pkg::op_indirect_jump_z: begin
                dec_pc = (op_in == cabu_pkg::op_relative_jump) ? pc_rel : z_ptr[PC_W-1:0];
                dec_cycles = `CABU_CYC_JUMP;
            end
            cabu_pkg::op_relative_call, cabu_pkg::op_indirect_call_z: begin
                dec_pc = (op_in == cabu_pkg::op_relative_call) ? pc_rel : z_ptr[PC_W-1:0];
                dec_cycles = `CABU_CYC_CALL;
                dec_call = 1'b1;
            end
            cabu_pkg::op_compare, cabu_pkg::op_compare_with_carry, cabu_pkg::op_compare_immediate: begin
                dec_func = cabu_pkg::func_sub;
                dec_b = (op_in == cabu_pkg::op_compare_immediate) ? imm_in : r_opnd;
                dec_use_carry = (op_in == cabu_pkg::op_compare_with_carry);
                dec_mask = `CABU_MASK_ARITH;
            end
            cabu_pkg::op_compare_skip_equal: begin
                dec_skip = (a_opnd == r_opnd);
            end
            cabu_pkg::op_skip_bit_clear: begin
                dec_skip = ~r_opnd[bit_sel_in];
            end
            cabu_pkg::op_skip_bit_set: begin
                dec_skip = r_opnd[bit_sel_in];
            end
            default: begin
            end
        endcase
        if (dec_skip) begin
            dec_pc = pc_skip;
            dec_cycles = `CABU_CYC_SKIP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // commit selection: one-cycle work commits at its start edge, longer work at its last edge

    wire start_single = start_acc && (dec_cycles == `CABU_CYC_SINGLE);
    wire last_busy = (state_reg == cabu_pkg::st_busy) && (cnt_reg == 2'h1);
    wire commit = start_single || last_busy;
    wire c_wr = start_single ? dec_wr : pend_wr_reg;
    wire c_wr_hi = start_single ? 1'b0 : pend_wr_hi_reg;
    wire [4:0] c_addr = start_single ? rd_sel_in : pend_addr_reg;
    wire [7:0] c_lo = start_single ? new_lo : pend_lo_reg;
    wire [7:0] c_flags = start_single ? new_flags : pend_flags_reg;
    wire [7:0] c_mask = start_single ? dec_mask : pend_mask_reg;
    wire [PC_W-1:0] c_pc = start_single ? dec_pc : pend_pc_reg;
    wire c_call = start_single ? 1'b0 : pend_call_reg;
    wire status_flags_hit = (reg_addr_in == `CABU_ADDR_STATUS_FLAGS);
    wire sp_hit = (reg_addr_in == `CABU_ADDR_STACK_POINTER);
    wire [7:0] status_flags_base = (reg_wr_in && status_flags_hit) ? reg_wdata_in : status_flags_reg;
    // only the masked flags change; the others keep their old or freshly written value
    wire [7:0] status_flags_next = commit ? ((status_flags_base & ~c_mask) | (c_flags & c_mask)) : status_flags_base;
    wire [7:0] sp_base = (reg_wr_in && sp_hit) ? reg_wdata_in : sp_reg;
    wire [7:0] sp_next = (commit && c_call) ? sp_base - `CABU_CALL_SP_STEP : sp_base;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= cabu_pkg::st_idle;
            cnt_reg <= 2'h0;
        end else if (start_acc && !start_single) begin
            state_reg <= cabu_pkg::st_busy;
            cnt_reg <= dec_cycles - 2'h1;
        end else if (last_busy) begin
            state_reg <= cabu_pkg::st_idle;
            cnt_reg <= 2'h0;
        end else if (state_reg == cabu_pkg::st_busy) begin
            cnt_reg <= cnt_reg - 2'h1;
        end
    end

    // capture results of multi-cycle work; operands are sampled at the start edge
    always_ff @(posedge clk_in) begin
        if (start_acc) begin
            pend_wr_reg <= dec_wr;
            pend_wr_hi_reg <= dec_word;
            pend_addr_reg <= rd_sel_in;
            pend_lo_reg <= new_lo;
            pend_hi_reg <= word_res[15:8];
            pend_flags_reg <= new_flags;
            pend_mask_reg <= dec_mask;
            pend_pc_reg <= dec_pc;
            pend_call_reg <= dec_call;
        end
    end

    // working registers; a commit overrides a port write to the same register
    always_ff @(posedge clk_in) begin
        if (rf_wr_in) begin
            rf[rf_addr_in] <= rf_wdata_in;
        end
        if (commit && c_wr) begin
            rf[c_addr] <= c_lo;
        end
        if (commit && c_wr_hi) begin
            rf[c_addr + 5'h01] <= pend_hi_reg;
        end
    end

    // architectural state and outputs
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            status_flags_reg <= `CABU_RST_STATUS_FLAGS;
            sp_reg <= `CABU_RST_STACK_POINTER;
            pc_reg <= '0;
            done_reg <= 1'b0;
            call_reg <= 1'b0;
            ret_reg <= '0;
        end else begin
            status_flags_reg <= status_flags_next;
            sp_reg <= sp_next;
            done_reg <= commit;
            call_reg <= commit && c_call;
            if (commit) begin
                pc_reg <= c_pc;
            end
            if (start_acc && dec_call) begin
                ret_reg <= pc_inc;
            end
        end
    end

    // register port: read data stands one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_data_reg <= 8'h00;
            rf_rd_reg <= 8'h00;
        end else begin
            rf_rd_reg <= rf[rf_addr_in];
            if (reg_rd_in) begin
                rd_data_reg <= status_flags_hit ? status_flags_reg : (sp_hit ? sp_reg : 8'h00);
            end else begin
                rd_data_reg <= 8'h00;
            end
        end
    end

    assign ready_out = (state_reg == cabu_pkg::st_idle);
    assign done_out = done_reg;
    assign pc_out = pc_reg;
    assign call_out = call_reg;
    assign return_addr_out = ret_reg;
    assign rf_rdata_out = rf_rd_reg;
    assign reg_rdata_out = rd_data_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    wire clean = start_acc && !rf_wr_in && !reg_wr_in;
    wire is_call = (op_in == cabu_pkg::op_relative_call) || (op_in == cabu_pkg::op_indirect_call_z);
    wire is_jump = (op_in == cabu_pkg::op_relative_jump) || (op_in == cabu_pkg::op_indirect_jump_z);
    wire is_word = (op_in == cabu_pkg::op_word_add_immediate) || word_sub;
    wire is_logic = (op_in == cabu_pkg::op_and) || (op_in == cabu_pkg::op_or) ||
        (op_in == cabu_pkg::op_exclusive_or_regs);
    wire is_skip_op = (op_in == cabu_pkg::op_skip_bit_set) || (op_in == cabu_pkg::op_skip_bit_clear) ||
        (op_in == cabu_pkg::op_compare_skip_equal);

    sequence busy_for_two;
        !ready_out ##1 ready_out;
    endsequence
    sequence busy_for_three;
        !ready_out [*2] ##1 ready_out;
    endsequence

    a_add_carry_sum: assert property (clean && op_in == cabu_pkg::op_add_carry |=>
        rf[$past(rd_sel_in)] == $past(a_opnd + r_opnd + {7'h00, carry_now}) && done_out)
        else $error("add with carry result wrong");
    a_word_two_cycles: assert property (clean && is_word |=> busy_for_two)
        else $error("word operation not two cycles");
    a_sub_zero_flag: assert property (clean && op_in == cabu_pkg::op_sub |=>
        status_flags_reg[`CABU_FLAG_Z] == (rf[$past(rd_sel_in)] == 8'h00) && ready_out)
        else $error("subtract zero flag wrong");
    a_logic_keeps_carry: assert property (clean && is_logic |=>
        status_flags_reg[`CABU_FLAG_C] == $past(status_flags_reg[`CABU_FLAG_C]) &&
        status_flags_reg[`CABU_FLAG_H] == $past(status_flags_reg[`CABU_FLAG_H]))
        else $error("logic operation touched carry");
    a_all_ones_load: assert property (clean && op_in == cabu_pkg::op_load_all_ones |=>
        rf[$past(rd_sel_in)] == `CABU_ALL_ONES && status_flags_reg == $past(status_flags_reg))
        else $error("all-ones load wrong");
    a_test_keeps_value: assert property (clean && op_in == cabu_pkg::op_test_register |=>
        rf[$past(rd_sel_in)] == $past(a_opnd) && status_flags_reg[`CABU_FLAG_V] == 1'b0)
        else $error("test changed register");
    a_jump_target: assert property (clean && is_jump |=> busy_for_two ##0
        pc_out == $past(dec_pc, 2) && status_flags_reg == $past(status_flags_reg, 2))
        else $error("jump target or timing wrong");
    a_call_three: assert property (clean && is_call |=> busy_for_three ##0
        call_out && pc_out == $past(dec_pc, 3))
        else $error("call timing wrong");
    a_skip_timing: assert property (clean && is_skip_op |=>
        (ready_out == !$past(dec_skip)) ##0 (ready_out or (!ready_out ##1 ready_out)))
        else $error("skip timing wrong");
    a_compare_no_write: assert property (clean && op_in == cabu_pkg::op_compare_immediate |=>
        rf[$past(rd_sel_in)] == $past(a_opnd) && status_flags_reg[`CABU_FLAG_C] == $past(alu_c))
        else $error("compare wrote result");

endmodule : cabu_core

//--- bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic start_in = 1'b0;
    cabu_pkg::cabu_op_type op_in = cabu_pkg::op_nop;
    logic [4:0] rd_sel_in = 5'h00;
    logic [4:0] rr_sel_in = 5'h00;
    logic [7:0] imm_in = 8'h00;
    logic [2:0] bit_sel_in = 3'h0;
    logic [11:0] offset_in = 12'h000;
    logic next_two_words_in = 1'b0;
    logic rf_wr_in = 1'b0;
    logic [4:0] rf_addr_in = 5'h00;
    logic [7:0] rf_wdata_in = 8'h00;
    logic [5:0] reg_addr_in = 6'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic ready_out, done_out, call_out;
    logic [10:0] pc_out, return_addr_out, pcx = 11'h000;
    logic [7:0] rf_rdata_out, reg_rdata_out, a, b, k, r, f, f0, sp, lfsr = 8'h3D;
    logic [8:0] s;
    logic [15:0] w;
    logic cin, sk;
    int err_count = 0;
    int total_checks = 0;
    cabu_pkg::cabu_op_type ar [8] = '{cabu_pkg::op_add, cabu_pkg::op_add_carry, cabu_pkg::op_sub,
        cabu_pkg::op_subtract_borrow, cabu_pkg::op_subtract_borrow_constant, cabu_pkg::op_compare_with_carry,
        cabu_pkg::op_subtract_constant, cabu_pkg::op_compare_immediate};
    cabu_pkg::cabu_op_type jp [4] = '{cabu_pkg::op_relative_jump, cabu_pkg::op_indirect_jump_z,
        cabu_pkg::op_relative_call, cabu_pkg::op_indirect_call_z};
    cabu_pkg::cabu_op_type sq [3] = '{cabu_pkg::op_compare_skip_equal, cabu_pkg::op_skip_bit_set,
        cabu_pkg::op_skip_bit_clear};

    cabu_core #(.PC_W(11)) cabu_core_i (.clk_in, .srst_in, .start_in, .op_in, .rd_sel_in, .rr_sel_in, .imm_in,
        .bit_sel_in, .offset_in, .next_two_words_in, .ready_out, .done_out, .pc_out, .call_out, .return_addr_out,
        .rf_wr_in, .rf_addr_in, .rf_wdata_in, .rf_rdata_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out);

    // 40 MHz clock
    always #12.5 clk_in = ~clk_in;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction : rnd

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one task serves both write ports, so only one strobe is ever raised
    task automatic put(input logic rf, input logic [5:0] ad, input logic [7:0] dt);
        @(posedge clk_in);
        rf_addr_in <= ad[4:0];
        reg_addr_in <= ad;
        rf_wdata_in <= dt;
        reg_wdata_in <= dt;
        rf_wr_in <= rf;
        reg_wr_in <= !rf;
        @(posedge clk_in);
        rf_wr_in <= 1'b0;
        reg_wr_in <= 1'b0;
    endtask : put

    // read data is only valid in the cycle right after the strobe edge
    task automatic get(input logic rf, input logic [5:0] ad, output logic [7:0] dt);
        @(posedge clk_in);
        rf_addr_in <= ad[4:0];
        reg_addr_in <= ad;
        reg_rd_in <= !rf;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 dt = rf ? rf_rdata_out : reg_rdata_out;
    endtask : get

    // source is always register 2; k doubles as offset, bit index and two-word hint
    task automatic run(input cabu_pkg::cabu_op_type o, input logic [4:0] d, input logic [7:0] kk, input int cyc,
                       input logic [10:0] pce);
        int n;
        @(posedge clk_in);
        op_in <= o;
        rd_sel_in <= d;
        rr_sel_in <= 5'h02;
        imm_in <= kk;
        bit_sel_in <= kk[2:0];
        next_two_words_in <= kk[3];
        offset_in <= {{4{kk[7]}}, kk};
        start_in <= 1'b1;
        @(posedge clk_in);
        start_in <= 1'b0;
        n = 1;
        #1;
        while (done_out !== 1'b1 && n < 8) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk(16'(n), 16'(cyc));
        chk(call_out, o inside {cabu_pkg::op_relative_call, cabu_pkg::op_indirect_call_z});
        if (o inside {cabu_pkg::op_relative_call, cabu_pkg::op_indirect_call_z}) begin
            chk(return_addr_out, pcx + 11'h001);
        end
        pcx = pce;
        chk(pc_out, pcx);
    endtask : run

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // watchdog far beyond the roughly five hundred cycles the sequence needs
    initial begin
        #400us;
        err_count++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_in);
        srst_in <= 1'b0;
        // stack pointer, unmapped offset 3E and status flags all read zero after reset
        for (int j = 0; j < 3; j++) begin
            get(1'b0, 6'h3D + 6'(j), r);
            chk(r, 8'h00);
        end
        sp = rnd();
        put(1'b0, 6'h3D, sp);
        get(1'b0, 6'h3D, r);
        chk(r, sp);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            a = (i == 0) ? 8'hFF : rnd();
            b = (i == 0) ? 8'h01 : rnd();
            k = rnd();
            cin = (i % 8 inside {1, 3, 4, 5}) & k[0];
            put(1'b1, 6'h01, a);
            put(1'b1, 6'h02, b);
            put(1'b0, 6'h3F, {1'b1, 6'h00, k[0]});
            run(ar[i % 8], 5'h01, b, 1, pcx + 11'h001);
            s = (i % 8 < 2) ? {1'b0, a} + {1'b0, b} + {8'h00, cin} : {1'b0, a} - {1'b0, b} - {8'h00, cin};
            get(1'b1, 6'h01, r);
            chk(r, (i % 8 inside {5, 7}) ? a : s[7:0]);
            get(1'b0, 6'h3F, f);
            chk({f[7], f[2:0]}, {1'b1, s[7], s[7:0] == 8'h00, s[8]});
        end
        $display("test arithmetic done");
        for (int j = 0; j < 12; j++) begin
            a = rnd();
            b = rnd();
            put(1'b1, 6'h01, a);
            put(1'b1, 6'h02, b);
            put(1'b0, 6'h3F, 8'h21);
            run(cabu_pkg::cabu_op_type'(5'(j + 7)), 5'h01, b, 1, pcx + 11'h001);
            case (j)
                0, 1: r = a & b;
                2, 3, 5: r = a | b;
                4: r = a ^ b;
                6: r = a & ~b;
                7: r = 8'hFF;
                8: r = a + 8'h01;
                9: r = a - 8'h01;
                10: r = a;
                default: r = 8'h00;
            endcase
            get(1'b1, 6'h01, f0);
            chk(f0, r);
            get(1'b0, 6'h3F, f);
            chk({f[5], f[2:0]}, {1'b1, (j == 7) ? 3'h1 : {r[7], r == 8'h00, 1'b1}});
        end
        $display("test logic done");
        for (int j = 0; j < 2; j++) begin
            a = rnd();
            b = (j == 0) ? 8'hFF : rnd();
            k = rnd();
            put(1'b1, 6'h18, a);
            put(1'b1, 6'h19, b);
            run(j ? cabu_pkg::op_word_subtract_immediate : cabu_pkg::op_word_add_immediate, 5'h18, k, 2,
                pcx + 11'h001);
            w = j ? {b, a} - {10'h000, k[5:0]} : {b, a} + {10'h000, k[5:0]};
            get(1'b1, 6'h18, r);
            chk(r, w[7:0]);
            get(1'b1, 6'h19, r);
            chk(r, w[15:8]);
        end
        for (int j = 0; j < 4; j++) begin
            a = rnd();
            k = rnd();
            f0 = rnd();
            put(1'b1, 6'h1E, k);
            put(1'b1, 6'h1F, a);
            put(1'b0, 6'h3F, f0);
            run(jp[j], 5'h01, k, 2 + j / 2, j[0] ? {a[2:0], k} : pcx + {{3{k[7]}}, k} + 11'h001);
            sp = sp - ((j > 1) ? 8'h02 : 8'h00);
            get(1'b0, 6'h3F, f);
            chk(f, f0);
            get(1'b0, 6'h3D, r);
            chk(r, sp);
        end
        for (int j = 0; j < 9; j++) begin
            a = rnd();
            b = j[0] ? a : rnd();
            k = rnd();
            put(1'b1, 6'h01, a);
            put(1'b1, 6'h02, b);
            sk = (j % 3 == 0) ? (a == b) : (b[k[2:0]] ^ (j % 3 == 2));
            run(sq[j % 3], 5'h01, k, sk ? 2 : 1, pcx + (sk ? (k[3] ? 11'h003 : 11'h002) : 11'h001));
        end
        $display("test flow done");
        print_verdict();
    end
endmodule : tb
